//--- inc/gadcs_pkg.sv
`default_nettype none
package gadcs_pkg;
   // ****************************************************
   // Global address map
   // ****************************************************
   localparam int ADDR_W = 23;
   localparam logic [22:0] CS3_BOT = 23'h00_0800;
   localparam logic [22:0] CS3_TOP = 23'h0F_FFFF;
   localparam logic [22:0] CS2A_BOT = 23'h10_0000;
   localparam logic [22:0] CS2A_TOP = 23'h13_FFFF;
   localparam logic [22:0] CS2B_BOT = 23'h14_0000;
   localparam logic [22:0] CS2B_TOP = 23'h1F_FFFF;
   localparam logic [22:0] CS1_BOT = 23'h20_0000;
   localparam logic [22:0] CS1_TOP = 23'h3F_FFFF;
   localparam logic [22:0] CS0_BOT = 23'h40_0000;
   localparam logic [22:0] CS0_TOP = 23'h7F_FFFF;
   localparam logic [22:0] PAGE_MASK = 23'h00_FFFF;
   // ****************************************************
   // Operating modes
   // ****************************************************
   typedef enum logic [2:0] {
      GADCS_NORMAL_SINGLE,
      GADCS_SPECIAL_SINGLE,
      GADCS_EMUL_SINGLE,
      GADCS_NORMAL_EXPANDED,
      GADCS_EMUL_EXPANDED,
      GADCS_SPECIAL_TEST
   } gadcs_mode_t;
   // ****************************************************
   // Access disposition
   // ****************************************************
   typedef enum logic [1:0] {
      GADCS_DO_INTERNAL,
      GADCS_DO_EXTERNAL,
      GADCS_DO_IGNORE,
      GADCS_DO_RESET
   } gadcs_action_t;
   localparam logic [3:0] CS_IDLE = 4'hF;
   localparam logic [1:0] ACT_RESET_VAL = 2'h0;
endpackage
`default_nettype wire

//--- core/gadcs_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Expanded modes except emulation single-chip send unimplemented/external accesses outward.
// - Emulation single-chip sends unimplemented-area accesses to the external bus.
// - Emulation single-chip CPU access to external space raises illegal access reset.
// - Emulation single-chip debug-port external accesses proceed, no reset, data undefined.
// - Single-chip CPU access to unimplemented area resets, unless firmware command.
// - Single-chip debug-port unimplemented accesses proceed, no reset, data undefined.
// - Misaligned word at non-RAM top byte: done expanded; single-chip resets except flash/firmware.
// - Misaligned word at RAM top byte: ignored expanded; single-chip resets except firmware.
// - Debug port never issues misaligned words; decoder treats none from it.
// - Global misaligned word at page end wraps to first byte of same page.
// - Chip selects only in normal/emulation expanded and special test, off-chip accesses, plus on-chip high-mapped flash for chip select two.
// - Chip select three spans its bottom to top less on-chip RAM size.
// - First chip select two range spans bottom to top less EEPROM size.
// - Chip select two also decodes upper range, even over flash when high-mapped.
// - Chip select one decodes its whole global range.
// - Chip select zero spans bottom to top less on-chip flash size.
// - With internal NVM enabled, chip select zero is off over that block.
module gadcs_decode (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Configuration
   input wire gadcs_pkg::gadcs_mode_t i_mode,
   input wire logic [22:0] i_onchip_ram_size,
   input wire logic [22:0] i_onchip_eeprom_size,
   input wire logic [22:0] i_onchip_flash_size,
   input wire logic i_flash_high_map_sel,
   input wire logic i_internal_nvm_enable,
   // Access request
   input wire logic i_acc_valid,
   input wire logic [22:0] i_acc_addr,
   input wire logic i_acc_word,
   input wire logic i_acc_debug_port,
   input wire logic i_acc_firmware,
   input wire logic i_acc_global,
   input wire logic i_hit_onchip,
   input wire logic i_hit_ram,
   input wire logic i_hit_flash,
   input wire logic i_hit_top_byte,
   input wire logic i_hit_unimpl,
   // Results
   output logic o_acc_valid,
   output gadcs_pkg::gadcs_action_t o_action,
   output logic o_data_undefined,
   output logic [22:0] o_second_addr,
   output logic o_illegal_reset,
   output logic o_chip_select_zero_n,
   output logic o_chip_select_one_n,
   output logic o_chip_select_two_n,
   output logic o_chip_select_three_n
);
   // ****************************************************
   // Mode groups
   // ****************************************************
   wire logic single_mode;
   wire logic emul_single;
   wire logic cs_mode;
   assign emul_single = (i_mode == gadcs_pkg::GADCS_EMUL_SINGLE);
   assign single_mode = (i_mode == gadcs_pkg::GADCS_NORMAL_SINGLE) ||
                        (i_mode == gadcs_pkg::GADCS_SPECIAL_SINGLE);
   assign cs_mode = (i_mode == gadcs_pkg::GADCS_NORMAL_EXPANDED) ||
                    (i_mode == gadcs_pkg::GADCS_EMUL_EXPANDED) ||
                    (i_mode == gadcs_pkg::GADCS_SPECIAL_TEST);

   function automatic logic in_rng(input logic [22:0] a, input logic [22:0] lo,
                                   input logic [22:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   // ****************************************************
   // Access classification
   // ****************************************************
   wire logic is_cpu;
   wire logic offchip;
   wire logic misal;
   wire logic ext_space;
   assign is_cpu = !i_acc_debug_port;
   assign offchip = !i_hit_onchip;
   assign ext_space = offchip && !i_hit_unimpl;
   assign misal = i_acc_word && i_acc_addr[0] && is_cpu;

   wire logic [22:0] second_addr_next;
   assign second_addr_next = (i_acc_global && ((i_acc_addr & gadcs_pkg::PAGE_MASK) ==
                             gadcs_pkg::PAGE_MASK)) ? (i_acc_addr & ~gadcs_pkg::PAGE_MASK)
                             : 23'(i_acc_addr + 23'h00_0001);

   gadcs_pkg::gadcs_action_t action_next;
   logic undef_next;
   always_comb begin
      action_next = gadcs_pkg::GADCS_DO_INTERNAL;
      undef_next = 1'b0;
      if (offchip) begin
         if (single_mode) begin
            if (is_cpu && !i_acc_firmware) begin
               action_next = gadcs_pkg::GADCS_DO_RESET;
            end else begin
               action_next = gadcs_pkg::GADCS_DO_INTERNAL;
               undef_next = !is_cpu;
            end
         end else if (emul_single && ext_space) begin
            if (is_cpu) begin
               action_next = gadcs_pkg::GADCS_DO_RESET;
            end else begin
               action_next = gadcs_pkg::GADCS_DO_EXTERNAL;
               undef_next = 1'b1;
            end
         end else begin
            action_next = gadcs_pkg::GADCS_DO_EXTERNAL;
         end
      end else if (misal && i_hit_top_byte) begin
         if (i_hit_ram) begin
            if (single_mode && !i_acc_firmware) begin
               action_next = gadcs_pkg::GADCS_DO_RESET;
            end else if (!single_mode) begin
               action_next = gadcs_pkg::GADCS_DO_IGNORE;
               undef_next = 1'b1;
            end
         end else if (single_mode && !i_acc_firmware && !i_hit_flash) begin
            action_next = gadcs_pkg::GADCS_DO_RESET;
         end
      end
   end

   // ****************************************************
   // Chip select decode
   // ****************************************************
   wire logic cs3_hit;
   wire logic cs2_hit;
   wire logic cs1_hit;
   wire logic cs0_hit;
   wire logic cs_ok;
   assign cs_ok = i_acc_valid && cs_mode && offchip;
   assign cs3_hit = in_rng(i_acc_addr, gadcs_pkg::CS3_BOT,
                           23'(gadcs_pkg::CS3_TOP - i_onchip_ram_size));
   // two ranges; high-mapped flash still selects
   assign cs2_hit = in_rng(i_acc_addr, gadcs_pkg::CS2A_BOT,
                           23'(gadcs_pkg::CS2A_TOP - i_onchip_eeprom_size)) ||
                    in_rng(i_acc_addr, gadcs_pkg::CS2B_BOT, gadcs_pkg::CS2B_TOP);
   assign cs1_hit = in_rng(i_acc_addr, gadcs_pkg::CS1_BOT, gadcs_pkg::CS1_TOP);
   // less flash; NVM enable keeps it off on-chip
   assign cs0_hit = in_rng(i_acc_addr, gadcs_pkg::CS0_BOT,
                           23'(gadcs_pkg::CS0_TOP - i_onchip_flash_size)) ||
                    (!i_internal_nvm_enable && i_acc_addr >= gadcs_pkg::CS0_BOT);
   wire logic cs2_flash_high;
   assign cs2_flash_high = i_acc_valid && cs_mode && i_flash_high_map_sel &&
                           in_rng(i_acc_addr, gadcs_pkg::CS2B_BOT, gadcs_pkg::CS2B_TOP);

   // ****************************************************
   // Output registers
   // ****************************************************
   // registered active-low selects
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_chip_select_three_n <= gadcs_pkg::CS_IDLE[3];
         o_chip_select_two_n <= gadcs_pkg::CS_IDLE[2];
         o_chip_select_one_n <= gadcs_pkg::CS_IDLE[1];
         o_chip_select_zero_n <= gadcs_pkg::CS_IDLE[0];
      end else begin
         o_chip_select_three_n <= !(cs_ok && cs3_hit);
         o_chip_select_two_n <= !((cs_ok && cs2_hit) || cs2_flash_high);
         o_chip_select_one_n <= !(cs_ok && cs1_hit);
         o_chip_select_zero_n <= !(cs_ok && cs0_hit && !i_hit_onchip);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_acc_valid <= 1'b0;
         o_action <= gadcs_pkg::gadcs_action_t'(gadcs_pkg::ACT_RESET_VAL);
         o_data_undefined <= 1'b0;
         o_second_addr <= '0;
         o_illegal_reset <= 1'b0;
      end else begin
         o_acc_valid <= i_acc_valid;
         o_action <= action_next;
         o_data_undefined <= i_acc_valid && undef_next;
         o_second_addr <= second_addr_next;
         o_illegal_reset <= i_acc_valid && (action_next == gadcs_pkg::GADCS_DO_RESET);
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   // emulation single-chip external CPU access
   emul_ext_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && emul_single && ext_space && is_cpu |=> o_illegal_reset)
      else $error("emulation single-chip external CPU access did not reset");
   emul_dbg_ok_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && emul_single && ext_space && !is_cpu |=> !o_illegal_reset && o_data_undefined)
      else $error("debug external access mishandled");
   single_unimpl_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && single_mode && offchip && is_cpu && !i_acc_firmware |=> o_illegal_reset)
      else $error("single-chip unimplemented access did not reset");
   dbg_no_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && !is_cpu |=> !o_illegal_reset)
      else $error("debug access raised reset");
   exp_route_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && cs_mode && offchip |=> o_action == gadcs_pkg::GADCS_DO_EXTERNAL)
      else $error("expanded off-chip access not routed outward");
   ram_top_ign_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && !single_mode && i_hit_onchip && misal && i_hit_top_byte && i_hit_ram
      |=> o_action == gadcs_pkg::GADCS_DO_IGNORE)
      else $error("RAM top misaligned access not ignored");
   cs_mode_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !cs_mode |=> o_chip_select_zero_n && o_chip_select_one_n && o_chip_select_two_n &&
      o_chip_select_three_n)
      else $error("chip select active in wrong mode");
   page_wrap_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_global && i_acc_addr[15:0] == 16'hFFFF |=> o_second_addr[15:0] == 16'h0000 &&
      o_second_addr[22:16] == $past(i_acc_addr[22:16]))
      else $error("page wrap address wrong");
   cs1_range_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      cs_ok && i_acc_addr[22:21] == 2'b01 |=> !o_chip_select_one_n)
      else $error("chip select one missing");
   // ****************************************************
   // Corner checks
   // ****************************************************
   // unimplemented goes outward
   emul_unimpl_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && emul_single && offchip && i_hit_unimpl |=>
      o_action == gadcs_pkg::GADCS_DO_EXTERNAL)
      else $error("emulation single-chip unimplemented access not routed outward");
   fw_no_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && single_mode && offchip && i_acc_firmware |=> !o_illegal_reset)
      else $error("firmware command raised reset");
   dbg_undef_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && single_mode && offchip && !is_cpu |=>
      o_data_undefined && o_action == gadcs_pkg::GADCS_DO_INTERNAL)
      else $error("debug unimplemented access mishandled");
   top_byte_rst_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && single_mode && i_hit_onchip && misal && i_hit_top_byte && !i_hit_ram &&
      !i_hit_flash && !i_acc_firmware |=> o_illegal_reset)
      else $error("single-chip top byte access did not reset");
   top_byte_exp_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && !single_mode && i_hit_onchip && !i_hit_ram |=>
      o_action == gadcs_pkg::GADCS_DO_INTERNAL && !o_illegal_reset)
      else $error("expanded top byte access not performed");
   ram_top_rst_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && single_mode && i_hit_onchip && misal && i_hit_top_byte && i_hit_ram &&
      !i_acc_firmware |=> o_illegal_reset)
      else $error("single-chip RAM top access did not reset");
   dbg_aligned_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && !is_cpu && i_hit_onchip |=> o_action == gadcs_pkg::GADCS_DO_INTERNAL)
      else $error("debug on-chip access not performed");
   page_step_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !(i_acc_global && i_acc_addr[15:0] == 16'hFFFF) |=>
      o_second_addr == 23'($past(i_acc_addr) + 23'h00_0001))
      else $error("second byte address wrong");
   cs3_range_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      cs_ok && i_acc_addr >= gadcs_pkg::CS3_BOT &&
      i_acc_addr <= 23'(gadcs_pkg::CS3_TOP - i_onchip_ram_size) |=> !o_chip_select_three_n)
      else $error("chip select three missing");
   cs2_range_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      cs_ok && i_acc_addr >= gadcs_pkg::CS2A_BOT &&
      i_acc_addr <= 23'(gadcs_pkg::CS2A_TOP - i_onchip_eeprom_size) |=> !o_chip_select_two_n)
      else $error("chip select two missing");
   cs2_high_map_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_acc_valid && cs_mode && i_flash_high_map_sel && i_acc_addr >= gadcs_pkg::CS2B_BOT &&
      i_acc_addr <= gadcs_pkg::CS2B_TOP |=> !o_chip_select_two_n)
      else $error("chip select two missing over high-mapped flash");
   cs0_range_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      cs_ok && i_acc_addr >= gadcs_pkg::CS0_BOT &&
      i_acc_addr <= 23'(gadcs_pkg::CS0_TOP - i_onchip_flash_size) |=> !o_chip_select_zero_n)
      else $error("chip select zero missing");
   cs0_nvm_off_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_internal_nvm_enable && i_acc_addr > 23'(gadcs_pkg::CS0_TOP - i_onchip_flash_size) |=>
      o_chip_select_zero_n)
      else $error("chip select zero active over enabled on-chip memory");
   // Ranges are disjoint for sane sizes, so two selects at once would mean bus contention.
   // one select only
   one_select_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $onehot0(~{o_chip_select_three_n, o_chip_select_two_n, o_chip_select_one_n,
      o_chip_select_zero_n}))
      else $error("more than one chip select active");
   // ****************************************************
   // Coverage
   // ****************************************************
   cov_ext_c: cover property (@(posedge i_core_clk) o_action == gadcs_pkg::GADCS_DO_EXTERNAL);
   cov_reset_c: cover property (@(posedge i_core_clk) o_illegal_reset);
   cov_ignore_c: cover property (@(posedge i_core_clk) o_action == gadcs_pkg::GADCS_DO_IGNORE);
   cov_cs0_c: cover property (@(posedge i_core_clk) !o_chip_select_zero_n);
   cov_undef_c: cover property (@(posedge i_core_clk) o_data_undefined);
endmodule
`default_nettype wire

//--- verif/gadcs_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// External memory stand-in
// ****************************************************
module gadcs_ext_mem (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Decoder results
   input wire logic i_acc_valid,
   input wire gadcs_pkg::gadcs_action_t i_action,
   input wire logic i_cs0_n,
   input wire logic i_cs1_n,
   input wire logic i_cs2_n,
   input wire logic i_cs3_n,
   // Observations
   output logic [7:0] o_sel_count,
   output logic o_multi_select
);
   logic [3:0] sel_n;
   logic [7:0] sel_count_reg;
   logic multi_reg;
   assign sel_n = {i_cs3_n, i_cs2_n, i_cs1_n, i_cs0_n};
   assign o_sel_count = sel_count_reg;
   assign o_multi_select = multi_reg;
   // Two devices enabled at once would fight on the data bus, so it is latched.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sel_count_reg <= 8'h00;
         multi_reg <= 1'b0;
      end else if (i_acc_valid && (i_action == gadcs_pkg::GADCS_DO_EXTERNAL)) begin
         if (sel_n != 4'hF) begin
            sel_count_reg <= sel_count_reg + 8'h01;
         end
         if ($countones(~sel_n) > 1) begin
            multi_reg <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- verif/global_access_decode_chip_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
module global_access_decode_chip_select_bench;
   // ****************************************************
   // Stimulus and observation
   // ****************************************************
   localparam logic [8:0] f_w = 9'h100, f_d = 9'h080, f_fw = 9'h040, f_g = 9'h020;
   localparam logic [8:0] f_on = 9'h010, f_rm = 9'h008, f_fl = 9'h004, f_tp = 9'h002;
   localparam logic [8:0] f_un = 9'h001;
   localparam gadcs_pkg::gadcs_mode_t m_ns = gadcs_pkg::GADCS_NORMAL_SINGLE;
   localparam gadcs_pkg::gadcs_mode_t m_es = gadcs_pkg::GADCS_EMUL_SINGLE;
   localparam gadcs_pkg::gadcs_mode_t m_nx = gadcs_pkg::GADCS_NORMAL_EXPANDED;
   logic i_core_clk, i_rst_n, i_acc_valid, i_flash_high_map_sel, i_internal_nvm_enable;
   logic cfg_hm, cfg_nvm;
   gadcs_pkg::gadcs_mode_t i_mode;
   logic [22:0] i_acc_addr, ram_sz, eep_sz, fl_sz;
   logic [8:0] flags;
   wire logic [3:0] cs_n;
   wire logic [7:0] sel_count;
   wire logic o_acc_valid, o_data_undefined, o_illegal_reset, multi;
   wire gadcs_pkg::gadcs_action_t o_action;
   wire logic [22:0] o_second_addr;
   int err_count = 0;
   int checked = 0;
   gadcs_decode gadcs_decode_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .i_mode(i_mode), .i_onchip_ram_size(ram_sz), .i_onchip_eeprom_size(eep_sz),
      .i_onchip_flash_size(fl_sz), .i_flash_high_map_sel(i_flash_high_map_sel),
      .i_internal_nvm_enable(i_internal_nvm_enable), .i_acc_valid(i_acc_valid),
      .i_acc_addr(i_acc_addr), .i_acc_word(flags[8]), .i_acc_debug_port(flags[7]),
      .i_acc_firmware(flags[6]), .i_acc_global(flags[5]), .i_hit_onchip(flags[4]),
      .i_hit_ram(flags[3]), .i_hit_flash(flags[2]), .i_hit_top_byte(flags[1]),
      .i_hit_unimpl(flags[0]), .o_acc_valid(o_acc_valid), .o_action(o_action),
      .o_data_undefined(o_data_undefined), .o_second_addr(o_second_addr),
      .o_illegal_reset(o_illegal_reset), .o_chip_select_zero_n(cs_n[0]),
      .o_chip_select_one_n(cs_n[1]), .o_chip_select_two_n(cs_n[2]),
      .o_chip_select_three_n(cs_n[3]));
   gadcs_ext_mem gadcs_ext_mem_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .i_acc_valid(o_acc_valid), .i_action(o_action), .i_cs0_n(cs_n[0]),
      .i_cs1_n(cs_n[1]), .i_cs2_n(cs_n[2]), .i_cs3_n(cs_n[3]),
      .o_sel_count(sel_count), .o_multi_select(multi));
   // ****************************************************
   // Shared tasks
   // ****************************************************
   task automatic report(input logic bad, input logic [22:0] got, input logic [22:0] exp);
      checked++;
      if (bad) begin
         err_count++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      report(got !== exp, 23'(got), 23'(exp));
   endtask
   task automatic chk_act(input gadcs_pkg::gadcs_action_t got,
                          input gadcs_pkg::gadcs_action_t exp);
      report(got !== exp, 23'(got), 23'(exp));
   endtask
   task automatic chk_cs(input logic [3:0] got, input logic [3:0] exp);
      report(got !== exp, 23'(got), 23'(exp));
   endtask
   task automatic chk_addr(input logic [22:0] got, input logic [22:0] exp);
      report(got !== exp, got, exp);
   endtask
   // Inputs change on one edge; the registered answer is judged just after the next.
   task automatic acc(input gadcs_pkg::gadcs_mode_t m, input logic [22:0] a, input logic [8:0] f);
      @(posedge i_core_clk);
      i_mode <= m;
      i_acc_addr <= a;
      flags <= f;
      i_acc_valid <= 1'b1;
      i_flash_high_map_sel <= cfg_hm;
      i_internal_nvm_enable <= cfg_nvm;
      @(posedge i_core_clk);
      #1;
   endtask
   task automatic finish_test;
      if (err_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic t_modes;
      acc(m_nx, 23'h20_1234, f_w);
      chk_act(o_action, gadcs_pkg::GADCS_DO_EXTERNAL);
      chk_cs(cs_n, 4'hD);
      chk_bit(o_acc_valid, 1'b1);
      acc(m_es, 23'h20_0000, f_un);
      chk_act(o_action, gadcs_pkg::GADCS_DO_EXTERNAL);
      acc(m_es, 23'h20_0000, 9'h000);
      chk_bit(o_illegal_reset, 1'b1);
      acc(m_es, 23'h20_0000, f_d);
      chk_bit(o_illegal_reset, 1'b0);
      chk_bit(o_data_undefined, 1'b1);
      for (int i = 0; i < 2; i++) begin
         acc(gadcs_pkg::gadcs_mode_t'(i), 23'h30_0000, f_un);
         chk_bit(o_illegal_reset, 1'b1);
         acc(gadcs_pkg::gadcs_mode_t'(i), 23'h30_0000, f_un | f_fw);
         chk_bit(o_illegal_reset, 1'b0);
         acc(gadcs_pkg::gadcs_mode_t'(i), 23'h30_0000, f_un | f_d);
         chk_bit(o_illegal_reset, 1'b0);
         chk_bit(o_data_undefined, 1'b1);
      end
      for (int i = 0; i < 6; i++) begin
         acc(gadcs_pkg::gadcs_mode_t'(i), 23'h20_0000, f_un | f_d);
         chk_cs(cs_n, (i >= 3) ? 4'hD : 4'hF);
      end
   endtask
   task automatic t_misaligned;
      acc(m_nx, 23'h13_FFFF, f_w | f_on | f_tp);
      chk_act(o_action, gadcs_pkg::GADCS_DO_INTERNAL);
      chk_addr(o_second_addr, 23'h14_0000);
      acc(m_ns, 23'h13_FFFF, f_w | f_on | f_tp);
      chk_bit(o_illegal_reset, 1'b1);
      acc(m_ns, 23'h7F_FFFF, f_w | f_on | f_tp | f_fl);
      chk_bit(o_illegal_reset, 1'b0);
      acc(m_ns, 23'h13_FFFF, f_w | f_on | f_tp | f_fw);
      chk_bit(o_illegal_reset, 1'b0);
      acc(m_nx, 23'h0F_FFFF, f_w | f_on | f_tp | f_rm);
      chk_act(o_action, gadcs_pkg::GADCS_DO_IGNORE);
      chk_bit(o_data_undefined, 1'b1);
      acc(m_ns, 23'h0F_FFFF, f_w | f_on | f_tp | f_rm | f_fw);
      chk_bit(o_illegal_reset, 1'b0);
      acc(m_ns, 23'h0F_FFFF, f_w | f_on | f_tp | f_rm | f_d);
      chk_bit(o_illegal_reset, 1'b0);
      acc(m_ns, 23'h0F_FFFF, f_w | f_g | f_on | f_tp | f_rm);
      chk_bit(o_illegal_reset, 1'b1);
      chk_addr(o_second_addr, 23'h0F_0000);
      acc(m_nx, 23'h25_1235, f_w | f_g);
      chk_addr(o_second_addr, 23'h25_1236);
   endtask
   task automatic t_ranges;
      logic [22:0] ra [14] = '{23'h00_07FF, 23'h00_0800, 23'h0F_BFFF, 23'h0F_C000,
         23'h10_0000, 23'h13_EFFF, 23'h13_F000, 23'h14_0000, 23'h1F_FFFF, 23'h20_0000,
         23'h3F_FFFF, 23'h40_0000, 23'h77_FFFF, 23'h78_0000};
      logic [3:0] rc [14] = '{4'hF, 4'h7, 4'h7, 4'hF, 4'hB, 4'hB, 4'hF, 4'hB, 4'hB,
         4'hD, 4'hD, 4'hE, 4'hE, 4'hE};
      for (int i = 0; i < 14; i++) begin
         acc(m_nx, ra[i], 9'h000);
         chk_cs(cs_n, rc[i]);
      end
      cfg_hm = 1'b1;
      acc(m_nx, 23'h1F_0000, f_on);
      chk_cs(cs_n, 4'hB);
      cfg_nvm = 1'b1;
      acc(m_nx, 23'h50_0000, f_on);
      chk_cs(cs_n, 4'hF);
      acc(m_nx, 23'h78_0000, 9'h000);
      chk_cs(cs_n, 4'hF);
      acc(m_nx, 23'h77_FFFF, 9'h000);
      chk_cs(cs_n, 4'hE);
   endtask
   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      i_core_clk = 1'b0;
      forever #20 i_core_clk = ~i_core_clk;
   end
   initial begin
      #200_000;
      err_count++;
      finish_test();
   end
   initial begin
      {i_rst_n, i_acc_valid, i_flash_high_map_sel, i_internal_nvm_enable} = 4'h0;
      {cfg_hm, cfg_nvm} = 2'h0;
      i_mode = m_ns;
      i_acc_addr = 23'h00_0000;
      flags = 9'h000;
      {ram_sz, eep_sz, fl_sz} = {23'h00_4000, 23'h00_1000, 23'h08_0000};
      repeat (11) @(posedge i_core_clk);
      #1;
      chk_bit(o_acc_valid, 1'b0);
      chk_cs(cs_n, 4'hF);
      @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      t_modes();
      t_misaligned();
      t_ranges();
      chk_bit(multi, 1'b0);
      chk_bit(sel_count != 8'h00, 1'b1);
      finish_test();
   end
endmodule
`default_nettype wire
